// ==== verilog/regacc_target.sv ====
// Operation
// - data NACK mid-write drops whole write
// - undefined sub-address reads return 0xFF
// - reads past register end return 0xFF
// - overrun write still updates base register
// - surplus overrun bytes never touch neighbours
// - multi-byte values travel low byte first
// - read serves the latched sub-address
// - full-length write at base updates register
// - interior start of plain registers reads 0xFF
// - status low or top byte writable alone
// - status middle bytes read-only, writes ignored
// - status base transfers one to four bytes
// - one-byte read at status top byte
// - two-byte read from status second byte
// - access locality taken from selector value
// - arbitration ranks four, three, two, one, zero
// - reserved selectors give modifier zero, high values extended
// - modifier one-hot, extended equals selector
// - selector is byte register at offset zero
`timescale 1ns/1ps
`default_nettype none
`include "regacc_regs.svh"

module regacc_target
   import regacc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2E
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic BUSY_I,
   input wire logic [15:0] STS_MID_I,
   input wire logic [5:0] LOC_REQ_I,
   output logic [7:0] LOC_SEL_O,
   output logic [7:0] ACC_LOC_O,
   output logic [7:0] LOC_MOD_O,
   output logic [5:0] GRANT_O,
   output logic [31:0] INT_EN_O,
   output logic [7:0] STS_CTRL_O,
   output logic [7:0] STS_TOP_O,
   output logic [1:0] STS_WR_O
);

   core_s r;
   core_s n;
   logic scl_s;
   logic scl_q;
   logic sda_s;
   logic sda_q;
   logic rise_ev;
   logic fall_ev;
   logic start_ev;
   logic stop_ev;
   logic commit;
   logic [8:0] q;
   logic [31:0] sts_word;

   // byte served for base sub-address plus burst index
   function automatic logic [7:0] rd_byte(
      input logic [7:0] sub,
      input logic [7:0] idx,
      input logic [7:0] loc,
      input logic [31:0] ie,
      input logic [31:0] sw
   );
      logic [8:0] p;
      p = {1'b0, sub} + {1'b0, idx};
      rd_byte = `FILL_BYTE;
      if (sub == `LOC_SEL_OFS && idx == 8'h00) begin
         rd_byte = loc;
      end else if (sub == `INT_EN_OFS && idx < 8'h04) begin
         rd_byte = ie[8*idx[1:0] +: 8];
      end else if (sub >= `STS_OFS && p <= {1'b0, `STS_TOP_OFS}) begin
         rd_byte = sw[8*p[1:0] +: 8];
      end
   endfunction

   assign scl_s = r.scl_p[1];
   assign scl_q = r.scl_p[2];
   assign sda_s = r.sda_p[1];
   assign sda_q = r.sda_p[2];
   assign rise_ev = scl_s & ~scl_q;
   assign fall_ev = ~scl_s & scl_q;
   assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
   assign sts_word = {r.sts_hi, STS_MID_I, r.sts_lo};

   always_comb begin
      n = r;
      commit = 1'b0;
      q = 9'h000;
      if (CE_I) begin
         n.sts_wr = 2'b00;
         n.scl_p = {r.scl_p[1], r.scl_p[0], SCL_I};
         n.sda_p = {r.sda_p[1], r.sda_p[0], SDA_I};
         // fixed-priority grant, reserved request lowest
         n.gnt = 6'h00;
         if (LOC_REQ_I[5]) begin
            n.gnt = 6'h20;
         end
         for (int k = 0; k < 5; k++) begin
            if (LOC_REQ_I[k]) begin
               n.gnt = 6'h01 << k;
            end
         end
         if (r.loc_sel <= `LOC_MAX) begin
            n.loc_mod = 8'h01 << r.loc_sel[2:0];
         end else if (r.loc_sel >= `LOC_EXT_MIN) begin
            n.loc_mod = r.loc_sel;
         end else begin
            n.loc_mod = 8'h00;
         end
         // staged write lands only at frame end, never after a NACK
         commit = (start_ev | stop_ev) & r.wpend & ~r.drop;
         if (commit) begin
            if (r.sub == `LOC_SEL_OFS) begin
               n.loc_sel = r.stage[7:0];
            end
            if (r.sub == `INT_EN_OFS && r.nwr == `INT_EN_LEN) begin
               n.int_en = r.stage;
            end
            for (int k = 0; k < 4; k++) begin
               q = {1'b0, r.sub} + 9'(k);
               if (3'(k) < r.nwr && r.sub >= `STS_OFS &&
                   q <= {1'b0, `STS_TOP_OFS}) begin
                  if (q[1:0] == 2'b00) begin
                     n.sts_lo = r.stage[8*k +: 8];
                     n.sts_wr[0] = 1'b1;
                  end
                  if (q[1:0] == 2'b11) begin
                     n.sts_hi = r.stage[8*k +: 8];
                     n.sts_wr[1] = 1'b1;
                  end
               end
            end
            // middle status bytes and other targets drop
         end
         if (start_ev | stop_ev) begin
            n.st = start_ev ? ST_ADDR : ST_IDLE;
            n.bitc = 4'h0;
            n.oe = 1'b0;
            n.wpend = 1'b0;
            n.drop = 1'b0;
         end else begin
            case (r.st)
               ST_ADDR, ST_SUB, ST_WDATA: begin
                  if (rise_ev) begin
                     n.sh = {r.sh[6:0], sda_s};
                     n.bitc = r.bitc + 4'h1;
                  end
                  if (fall_ev && r.bitc == `BYTE_BITS) begin
                     n.bitc = 4'h0;
                     if (r.st == ST_ADDR) begin
                        if (r.sh[7:1] == DEV_ADDR) begin
                           n.rw = r.sh[0];
                           n.oe = 1'b1;
                           n.acc_loc = r.loc_sel;
                           n.st = ST_ADDR_ACK;
                        end else begin
                           n.st = ST_IDLE;
                        end
                     end else if (r.st == ST_SUB) begin
                        n.sub = r.sh;
                        n.idx = 8'h00;
                        n.nwr = 3'h0;
                        n.oe = 1'b1;
                        n.st = ST_SUB_ACK;
                     end else if (BUSY_I) begin
                        n.drop = 1'b1;
                        n.st = ST_IDLE;
                     end else begin
                        if (r.nwr < `STG_LEN) begin
                           n.stage[8*r.nwr[1:0] +: 8] = r.sh;
                           n.nwr = r.nwr + 3'h1;
                        end
                        n.wpend = 1'b1;
                        n.oe = 1'b1;
                        n.st = ST_WDATA_ACK;
                     end
                  end
               end
               ST_ADDR_ACK, ST_SUB_ACK, ST_WDATA_ACK: begin
                  if (fall_ev) begin
                     n.oe = 1'b0;
                     if (r.st == ST_ADDR_ACK && r.rw) begin
                        n.sh = rd_byte(r.sub, r.idx, r.loc_sel,
                           r.int_en, sts_word);
                        n.oe = ~n.sh[7];
                        n.bitc = 4'h0;
                        n.st = ST_RDATA;
                     end else if (r.st == ST_ADDR_ACK) begin
                        n.st = ST_SUB;
                     end else begin
                        n.st = ST_WDATA;
                     end
                  end
               end
               ST_RDATA: begin
                  if (rise_ev) begin
                     n.bitc = r.bitc + 4'h1;
                  end
                  if (fall_ev) begin
                     if (r.bitc == `BYTE_BITS) begin
                        n.oe = 1'b0;
                        if (r.idx != 8'hFF) begin
                           n.idx = r.idx + 8'h01;
                        end
                        n.st = ST_RACK;
                     end else begin
                        n.sh = {r.sh[6:0], 1'b0};
                        n.oe = ~r.sh[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (rise_ev) begin
                     n.nack = sda_s;
                  end
                  if (fall_ev) begin
                     if (!r.nack) begin
                        n.sh = rd_byte(r.sub, r.idx, r.loc_sel,
                           r.int_en, sts_word);
                        n.oe = ~n.sh[7];
                        n.bitc = 4'h0;
                        n.st = ST_RDATA;
                     end else begin
                        n.st = ST_IDLE;
                     end
                  end
               end
               default: begin
                  n.oe = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         r <= '0;
         r.st <= ST_IDLE;
         r.loc_sel <= `LOC_SEL_RST;
         r.int_en <= `INT_EN_RST;
         r.sts_lo <= `STS_BYTE_RST;
         r.sts_hi <= `STS_BYTE_RST;
         r.scl_p <= `SYNC_IDLE;
         r.sda_p <= `SYNC_IDLE;
      end else begin
         r <= n;
      end
   end

   // open-drain link: only ever pulls low
   assign SDA_O = 1'b0;
   assign SDA_OE_O = r.oe;
   assign LOC_SEL_O = r.loc_sel;
   assign ACC_LOC_O = r.acc_loc;
   assign LOC_MOD_O = r.loc_mod;
   assign GRANT_O = r.gnt;
   assign INT_EN_O = r.int_en;
   assign STS_CTRL_O = r.sts_lo;
   assign STS_TOP_O = r.sts_hi;
   assign STS_WR_O = r.sts_wr;

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   sequence s_commit;
      CE_I && (start_ev || stop_ev) && r.wpend && !r.drop;
   endsequence
   sequence s_dropped_end;
      CE_I && (start_ev || stop_ev) && r.drop;
   endsequence
   sequence s_read_load;
      r.st == ST_RDATA && r.bitc == 4'h0;
   endsequence

   sequence s_byte_done(phase_e ph);
      CE_I && r.st == ph && fall_ev && r.bitc == `BYTE_BITS;
   endsequence

   chk_data_nack: assert property (
      s_byte_done(ST_WDATA) ##0 BUSY_I |=> r.drop && !SDA_OE_O ##1
         !SDA_OE_O)
      else $error("busy data byte was not refused");

   chk_drop_keeps: assert property (
      s_dropped_end |=> $stable(INT_EN_O) && $stable(LOC_SEL_O) &&
         $stable(STS_CTRL_O) && $stable(STS_TOP_O))
      else $error("refused write changed a register");

   chk_undef_fill: assert property (
      s_read_load ##0 (r.sub >= 8'h20 || r.sub == 8'h04) |->
         r.sh == `FILL_BYTE)
      else $error("undefined sub-address did not read 0xFF");

   chk_overrun_fill: assert property (
      s_read_load ##0 (r.sub == `LOC_SEL_OFS && r.idx != 8'h00) |->
         r.sh == `FILL_BYTE)
      else $error("read past selector end did not read 0xFF");

   chk_interior_fill: assert property (
      s_read_load ##0 (r.sub == 8'h09) |-> r.sh == `FILL_BYTE)
      else $error("interior enable word start did not read 0xFF");

   chk_enable_commit: assert property (
      s_commit ##0 (r.sub == `INT_EN_OFS && r.nwr == `INT_EN_LEN) |=>
         INT_EN_O == $past(r.stage))
      else $error("full enable word write not applied");

   chk_status_low: assert property (
      s_commit ##0 (r.sub == `STS_OFS && r.nwr == 3'h1) |=>
         STS_CTRL_O == $past(r.stage[7:0]) && $stable(STS_TOP_O) &&
         STS_WR_O == 2'b01 ##1 STS_WR_O == 2'b00)
      else $error("single status low byte write wrong");

   chk_status_top: assert property (
      s_commit ##0 (r.sub == `STS_TOP_OFS && r.nwr != 3'h0) |=>
         STS_TOP_O == $past(r.stage[7:0]) && $stable(STS_CTRL_O))
      else $error("single status top byte write wrong");

   chk_status_top_rd: assert property (
      s_read_load ##0 (r.sub == `STS_TOP_OFS && r.idx == 8'h00) |->
         r.sh == r.sts_hi)
      else $error("status top byte read wrong");

   chk_sub_held: assert property (
      CE_I && (r.st == ST_RDATA || r.st == ST_RACK) |=> $stable(r.sub))
      else $error("sub-address moved during a read");

   chk_addr_ack: assert property (
      s_byte_done(ST_ADDR) ##0 r.sh[7:1] == DEV_ADDR |=>
         SDA_OE_O && ACC_LOC_O == $past(r.loc_sel))
      else $error("address match not acknowledged");

   chk_loc_onehot: assert property (
      CE_I && r.loc_sel <= `LOC_MAX |=>
         LOC_MOD_O == (8'h01 << $past(r.loc_sel[2:0])))
      else $error("locality modifier not one-hot");

   chk_loc_ext: assert property (
      CE_I && r.loc_sel >= `LOC_EXT_MIN |=> LOC_MOD_O == $past(r.loc_sel))
      else $error("extended modifier differs from selector");

   chk_grant_top: assert property (
      CE_I && LOC_REQ_I[4] |=> GRANT_O == 6'h10)
      else $error("locality four not granted first");

   chk_grant_zero: assert property (
      CE_I && LOC_REQ_I == 6'h21 |=> GRANT_O == 6'h01)
      else $error("locality zero lost to reserved request");

   chk_grant_res: assert property (
      CE_I && LOC_REQ_I == 6'h20 |=> GRANT_O == 6'h20)
      else $error("reserved request not granted alone");

endmodule

`default_nettype wire

// ==== verilog/regacc_regs.svh ====
`ifndef REGACC_REGS_SVH
`define REGACC_REGS_SVH

// sub-address offsets
`define LOC_SEL_OFS 8'h00
`define INT_EN_OFS 8'h08
`define STS_OFS 8'h18
`define STS_TOP_OFS 8'h1B

// register lengths in bytes
`define INT_EN_LEN 3'h4
`define STG_LEN 3'h4

// byte returned for undefined or overrun reads
`define FILL_BYTE 8'hFF

// reset values
`define LOC_SEL_RST 8'h00
`define INT_EN_RST 32'h0000_0000
`define STS_BYTE_RST 8'h00
// bus line synchronisers start at the idle-high level
`define SYNC_IDLE 3'h7

// locality selector encoding
`define LOC_MAX 8'h04
`define LOC_EXT_MIN 8'h20

// bits per byte on the link
`define BYTE_BITS 4'h8

`endif

// ==== verilog/regacc_pkg.sv ====
`default_nettype none

package regacc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_SUB = 4'b0011,
      ST_SUB_ACK = 4'b0100,
      ST_WDATA = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA = 4'b0111,
      ST_RACK = 4'b1000
   } phase_e;

   typedef struct packed {
      logic [2:0] scl_p;
      logic [2:0] sda_p;
      phase_e st;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic rw;
      logic nack;
      logic [7:0] sub;
      logic [7:0] idx;
      logic [2:0] nwr;
      logic [31:0] stage;
      logic wpend;
      logic drop;
      logic oe;
      logic [7:0] loc_sel;
      logic [7:0] acc_loc;
      logic [7:0] loc_mod;
      logic [5:0] gnt;
      logic [31:0] int_en;
      logic [7:0] sts_lo;
      logic [7:0] sts_hi;
      logic [1:0] sts_wr;
   } core_s;

endpackage

`default_nettype wire

// ==== dv/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model #(
   parameter logic [6:0] ADDR = 7'h2E // arbitrary target address
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic pull_o
);
   // clock stands high between frames, data line released
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one bit: data set late in the low phase, sampled in the high phase
   task automatic bit_x(input logic v, output logic s);
      wt(5);
      pull_o <= ~v;
      wt(1);
      scl_o <= 1'b1;
      wt(1);
      s = sda_i;
      wt(1);
      scl_o <= 1'b0;
   endtask

   // msb first within a byte, then the acknowledge bit
   task automatic byte_x(input logic [7:0] tx, input logic ak,
                         output logic [7:0] rx, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
      bit_x(ak, nak);
   endtask

   task automatic start_c;
      wt(5);
      pull_o <= 1'b0;
      wt(1);
      scl_o <= 1'b1;
      wt(2);
      pull_o <= 1'b1;
      wt(2);
      scl_o <= 1'b0;
   endtask

   task automatic stop_c;
      wt(5);
      pull_o <= 1'b1;
      wt(1);
      scl_o <= 1'b1;
      wt(2);
      pull_o <= 1'b0;
      wt(6);
   endtask

   // start, target address with write direction, sub-address
   task automatic head(input logic [7:0] sub, output logic nak);
      logic [7:0] r;
      logic n2;
      start_c();
      byte_x({ADDR, 1'b0}, 1'b1, r, nak);
      byte_x(sub, 1'b1, r, n2);
   endtask

   // bytes go out low byte first; stops sending after a refusal
   task automatic write_regs(input logic [7:0] sub, input int n,
                             input logic [39:0] d, output logic nak);
      logic [7:0] r;
      head(sub, nak);
      // an address refusal is retried once after the guard wait
      if (nak) begin
         stop_c();
         #2ms;
         wt(1);
         head(sub, nak);
      end
      for (int k = 0; k < n; k++) begin
         if (!nak) byte_x(d[8*k +: 8], 1'b1, r, nak);
      end
      stop_c();
   endtask

   // repeated start, read direction, last byte not acknowledged
   task automatic read_regs(input logic [7:0] sub, input int n,
                            output logic [39:0] d);
      logic [7:0] r;
      logic nak;
      d = '0;
      head(sub, nak);
      start_c();
      byte_x({ADDR, 1'b1}, 1'b1, r, nak);
      for (int k = 0; k < n; k++) begin
         byte_x(8'hFF, k == n - 1, r, nak);
         d[8*k +: 8] = r;
      end
      stop_c();
   endtask
endmodule

`default_nettype wire

// ==== dv/tb_i2c_register_access_layer.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_i2c_register_access_layer;
   logic clk;
   logic rst_n;
   logic busy;
   logic [15:0] sts_mid;
   logic [5:0] loc_req;
   wire scl;
   wire pull;
   wire sda_o;
   wire sda_oe;
   wire sda;
   logic [7:0] loc_sel;
   logic [7:0] acc_loc;
   logic [7:0] loc_mod;
   logic [7:0] sts_ctrl;
   logic [7:0] sts_top;
   logic [5:0] grant;
   logic [31:0] int_en;
   logic [39:0] rd;
   logic nak;
   int n_fail = 0;
   int n_checks = 0;
   logic [7:0] sel_v [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h1F,
                             8'h20, 8'hFF};
   logic [7:0] mod_v [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h00,
                             8'h20, 8'hFF};
   logic [5:0] req_v [7] = '{6'h3F, 6'h0F, 6'h07, 6'h03, 6'h01, 6'h20, 6'h21};
   logic [5:0] gnt_v [7] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h20, 6'h01};

   // open-drain line with pull-up
   assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;

   regacc_target uut (
      .REF_CLK_I(clk),
      .RST_N_I(rst_n),
      .CE_I(1'b1),
      .SCL_I(scl),
      .SDA_I(sda),
      .SDA_O(sda_o),
      .SDA_OE_O(sda_oe),
      .BUSY_I(busy),
      .STS_MID_I(sts_mid),
      .LOC_REQ_I(loc_req),
      .LOC_SEL_O(loc_sel),
      .ACC_LOC_O(acc_loc),
      .LOC_MOD_O(loc_mod),
      .GRANT_O(grant),
      .INT_EN_O(int_en),
      .STS_CTRL_O(sts_ctrl),
      .STS_TOP_O(sts_top),
      .STS_WR_O()
   );

   i2c_host_model host (
      .clk_i(clk),
      .sda_i(sda),
      .scl_o(scl),
      .pull_o(pull)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] sub, input int n,
                     input logic [39:0] d);
      host.write_regs(sub, n, d, nak);
   endtask

   task automatic rdb(input logic [7:0] sub, input int n);
      host.read_regs(sub, n, rd);
   endtask

   initial begin
      rst_n = 1'b0;
      busy = 1'b0;
      sts_mid = 16'h5A3C;
      loc_req = 6'h00;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(int_en, 40'h0);
      check(loc_sel, 40'h0);
      wr(8'h08, 4, 40'h44332211);
      check(nak, 1'b0);
      check(int_en, 40'h44332211);
      rdb(8'h08, 5);
      check(rd, 40'hFF44332211);
      rdb(8'h08, 1);
      check(rd, 40'h11);
      rdb(8'h09, 2);
      check(rd, 40'hFFFF);
      rdb(8'h30, 1);
      check(rd, 40'hFF);
      wr(8'h08, 5, 40'h99DDCCBBAA);
      check(int_en, 40'hDDCCBBAA);
      check(sts_ctrl, 40'h0);
      wr(8'h08, 2, 40'h5566);
      check(int_en, 40'hDDCCBBAA);
      busy <= 1'b1;
      wr(8'h08, 4, 40'h01020304);
      busy <= 1'b0;
      check(nak, 1'b1);
      check(int_en, 40'hDDCCBBAA);
      wr(8'h18, 1, 40'hAA);
      check(sts_ctrl, 40'hAA);
      wr(8'h1B, 1, 40'h77);
      check(sts_top, 40'h77);
      wr(8'h18, 4, 40'h44332211);
      check({sts_top, sts_ctrl}, 40'h4411);
      rdb(8'h18, 4);
      check(rd, 40'h445A3C11);
      rdb(8'h1B, 1);
      check(rd, 40'h44);
      rdb(8'h19, 2);
      check(rd, 40'h5A3C);
      for (int i = 0; i < 9; i++) begin
         wr(8'h00, 1, {32'h0, sel_v[i]});
         check(loc_sel, sel_v[i]);
         check(loc_mod, mod_v[i]);
         rdb(8'h00, 2);
         check(rd, {24'h0, 8'hFF, sel_v[i]});
         check(acc_loc, sel_v[i]);
      end
      for (int i = 0; i < 7; i++) begin
         loc_req <= req_v[i];
         repeat (2) @(posedge clk);
         check(grant, gnt_v[i]);
      end
      report_and_stop();
   end

   // cuts a hang short
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
endmodule

`default_nettype wire
